// ===== hdl/brfx_consts.vh
/*
 * brfx_consts.vh - offsets, field positions, reset values, operation codes
 * and timing counts for the branch and file operation execution block.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef BRFX_CONSTS_VH
`define BRFX_CONSTS_VH

// timing
`define BRFX_CLK_PS         5000
`define BRFX_TCY_PS         20000
`define BRFX_TCY_CLKS       (`BRFX_TCY_PS / `BRFX_CLK_PS)

// register byte offsets
`define BRFX_OFF_INSTR      8'h00
`define BRFX_OFF_STATUS     8'h04
`define BRFX_OFF_PTR        8'h08
`define BRFX_OFF_WREG       8'h0C
`define BRFX_OFF_STACK      8'h10
`define BRFX_OFF_WDOG       8'h14
`define BRFX_OFF_EXEC       8'h18
`define BRFX_OFF_FILE       8'h80

// instruction register fields
`define BRFX_F_OP_LSB       0
`define BRFX_F_DEST         4
`define BRFX_F_FA_LSB       8
`define BRFX_F_LIT_LSB      16

// status register fields
`define BRFX_F_ZERO         2
`define BRFX_F_PWRDN        3
`define BRFX_F_TMOUT        4
`define BRFX_F_PAGE_LSB     5

// watchdog register fields
`define BRFX_F_WCNT_LSB     0
`define BRFX_F_PSC_LSB      8
`define BRFX_F_PSA          16

// reset values
`define BRFX_RST_STATUS     8'h18
`define BRFX_RST_PTR        11'h000
`define BRFX_RST_PSA        1'h1

// operation codes
`define BRFX_OP_NOP         4'h0
`define BRFX_OP_CALL        4'h1
`define BRFX_OP_BRANCH      4'h2
`define BRFX_OP_WDCLR       4'h3
`define BRFX_OP_FCLR        4'h4
`define BRFX_OP_FCPL        4'h5
`define BRFX_OP_FDEC        4'h6
`define BRFX_OP_DECSKP      4'h7

`endif

// ===== hdl/brfx_exec.v
/*
 * brfx_exec.v - executes subroutine call, unconditional branch, watchdog
 * clear and the file clear/complement/decrement/decrement-skip operations
 * on a 32-entry file, working register, status and instruction pointer.
 * Assumes one AHB-Lite master issuing single word transfers; the external
 * return stack takes stk_push pulses; watchdog counting lives elsewhere.
 */
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
// Contract
// - call pushes instruction pointer plus one onto the return stack.
// - call loads its eight-bit literal into pointer bits 7..0.
// - call takes pointer bits 10..9 from status 6..5, clears bit 8.
// - call takes two instruction cycles, status flags untouched.
// - watchdog clear zeroes counter, and prescaler only when assigned to it.
// - watchdog clear sets timeout and power-down flags.
// - file clear writes zero to addressed file entry and sets zero flag.
// - destination bit zero writes working register, one writes file entry.
// - complement inverts file entry, only zero flag changes.
// - decrement subtracts one, only zero flag changes.
// - decrement-skip leaves flags; zero result discards next, two cycles.
// - branch loads nine-bit literal to bits 8..0, bits 10..9 from status.
// - branch takes two instruction cycles, status flags untouched.
`timescale 1ns/1ps
`default_nettype none
`include "brfx_consts.vh"

module brfx_exec
(
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    // return stack
    output reg         stk_push,
    output reg  [10:0] stk_data,
    // watchdog side
    output reg         wdog_clr,
    output reg         psc_clr
);

localparam ST_IDLE = 2'b00;
localparam ST_PEND = 2'b01;
localparam ST_FLSH = 2'b10;

////////////////////////////////////////////////////////////////////////////////
// instruction cycle divider

reg  [7:0]  div_r;
wire        tick = (div_r == (`BRFX_TCY_CLKS - 1));

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
        div_r <= 8'h00;
    else if (tick)
        div_r <= 8'h00;
    else
        div_r <= div_r + 8'h01;
end

////////////////////////////////////////////////////////////////////////////////
// bus address phase capture

reg         a_wr_r;
reg         a_rd_r;
reg  [7:0]  a_addr_r;
wire        ap = hsel & htrans[1] & hready;
wire        bw = a_wr_r;

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        a_wr_r   <= 1'b0;
        a_rd_r   <= 1'b0;
        a_addr_r <= 8'h00;
    end
    else
    begin
        a_wr_r <= ap & hwrite;
        a_rd_r <= ap & ~hwrite;
        if (ap)
            a_addr_r <= haddr[7:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// architectural state

reg  [1:0]   st_r;
reg  [3:0]   op_r;
reg          dst_r;
reg  [4:0]   fa_r;
reg  [8:0]   lit_r;
reg  [7:0]   status_r;
reg  [10:0]  ptr_r;
reg  [7:0]   wreg_r;
reg  [7:0]   wcnt_r;
reg  [7:0]   psc_r;
reg          psa_r;
reg  [1:0]   ncyc_r;
reg  [3:0]   lastop_r;
wire [255:0] file_flat;

wire [7:0]   fval    = file_flat[fa_r*8 +: 8];
wire         exec    = (st_r == ST_PEND) & tick;
wire         is_rmw  = (op_r == `BRFX_OP_FCPL) | (op_r == `BRFX_OP_FDEC) |
                       (op_r == `BRFX_OP_DECSKP);
wire         wr_file = exec & ((op_r == `BRFX_OP_FCLR) | (is_rmw & dst_r));
wire         wr_w    = exec & is_rmw & ~dst_r;
wire         bw_inst = bw & (a_addr_r == `BRFX_OFF_INSTR) & (st_r == ST_IDLE);

reg  [7:0]   res;
always @*
begin
    case (op_r)
        `BRFX_OP_FCPL:   res = ~fval;
        `BRFX_OP_FDEC:   res = fval - 8'h01;
        `BRFX_OP_DECSKP: res = fval - 8'h01;
        default:         res = 8'h00;
    endcase
end

wire         res_zero = (res == 8'h00);
wire         skip     = (op_r == `BRFX_OP_DECSKP) & res_zero;
wire         two_cyc  = (op_r == `BRFX_OP_CALL) | (op_r == `BRFX_OP_BRANCH) | skip;
wire [10:0]  ptr_inc  = ptr_r + 11'h001;

////////////////////////////////////////////////////////////////////////////////
// file entries, one flop group per address

genvar gi;
generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_file
        reg  [7:0] ent_r;
        wire       hit_x = wr_file & (fa_r == gi);
        wire       hit_b = bw & (a_addr_r == (`BRFX_OFF_FILE + gi * 4));
        always @(posedge clk or negedge rstn)
        begin
            if (!rstn)
                ent_r <= 8'h00;
            else if (hit_x)
                ent_r <= res;
            else if (hit_b)
                ent_r <= hwdata[7:0];
        end
        assign file_flat[gi*8 +: 8] = ent_r;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// sequencer and core registers

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        st_r     <= ST_IDLE;
        op_r     <= `BRFX_OP_NOP;
        dst_r    <= 1'b0;
        fa_r     <= 5'h00;
        lit_r    <= 9'h000;
        status_r <= `BRFX_RST_STATUS;
        ptr_r    <= `BRFX_RST_PTR;
        wreg_r   <= 8'h00;
        wcnt_r   <= 8'h00;
        psc_r    <= 8'h00;
        psa_r    <= `BRFX_RST_PSA;
        ncyc_r   <= 2'b00;
        lastop_r <= `BRFX_OP_NOP;
        stk_push <= 1'b0;
        stk_data <= 11'h000;
        wdog_clr <= 1'b0;
        psc_clr  <= 1'b0;
    end
    else
    begin
        stk_push <= 1'b0;
        wdog_clr <= 1'b0;
        psc_clr  <= 1'b0;
        // software writes first; execution below overrides the same fields
        if (bw_inst)
        begin
            op_r  <= hwdata[`BRFX_F_OP_LSB +: 4];
            dst_r <= hwdata[`BRFX_F_DEST];
            fa_r  <= hwdata[`BRFX_F_FA_LSB +: 5];
            lit_r <= hwdata[`BRFX_F_LIT_LSB +: 9];
            st_r  <= ST_PEND;
        end
        if (bw & (a_addr_r == `BRFX_OFF_STATUS))
            status_r <= hwdata[7:0];
        if (bw & (a_addr_r == `BRFX_OFF_PTR) & (st_r == ST_IDLE))
            ptr_r <= hwdata[10:0];
        if (bw & (a_addr_r == `BRFX_OFF_WREG))
            wreg_r <= hwdata[7:0];
        if (bw & (a_addr_r == `BRFX_OFF_WDOG))
        begin
            wcnt_r <= hwdata[`BRFX_F_WCNT_LSB +: 8];
            psc_r  <= hwdata[`BRFX_F_PSC_LSB +: 8];
            psa_r  <= hwdata[`BRFX_F_PSA];
        end
        if (exec)
        begin
            lastop_r <= op_r;
            ncyc_r   <= 2'b01;
            st_r     <= two_cyc ? ST_FLSH : ST_IDLE;
            case (op_r)
                `BRFX_OP_CALL:
                begin
                    stk_push <= 1'b1;
                    stk_data <= ptr_inc;
                    ptr_r    <= {status_r[`BRFX_F_PAGE_LSB +: 2], 1'b0, lit_r[7:0]};
                end
                `BRFX_OP_BRANCH:
                    ptr_r <= {status_r[`BRFX_F_PAGE_LSB +: 2], lit_r};
                `BRFX_OP_WDCLR:
                begin
                    ptr_r    <= ptr_inc;
                    wcnt_r   <= 8'h00;
                    wdog_clr <= 1'b1;
                    if (psa_r)
                    begin
                        psc_r   <= 8'h00;
                        psc_clr <= 1'b1;
                    end
                    status_r[`BRFX_F_TMOUT] <= 1'b1;
                    status_r[`BRFX_F_PWRDN] <= 1'b1;
                end
                `BRFX_OP_FCLR:
                begin
                    ptr_r <= ptr_inc;
                    status_r[`BRFX_F_ZERO] <= 1'b1;
                end
                `BRFX_OP_FCPL, `BRFX_OP_FDEC:
                begin
                    ptr_r <= ptr_inc;
                    status_r[`BRFX_F_ZERO] <= res_zero;
                end
                default:
                    ptr_r <= ptr_inc;
            endcase
            if (wr_w)
                wreg_r <= res;
        end
        else if ((st_r == ST_FLSH) & tick)
        begin
            // second cycle runs as a no-op; skip steps over the fetched word
            st_r   <= ST_IDLE;
            ncyc_r <= 2'b10;
            if (lastop_r == `BRFX_OP_DECSKP)
                ptr_r <= ptr_inc;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// bus read mux and response, one wait state on reads

reg  [31:0] rmux;
always @*
begin
    rmux = 32'h0000_0000;
    case (a_addr_r)
        `BRFX_OFF_INSTR:  rmux = {7'h00, lit_r, 3'h0, fa_r, 3'h0, dst_r, op_r};
        `BRFX_OFF_STATUS: rmux = {24'h00_0000, status_r};
        `BRFX_OFF_PTR:    rmux = {21'h00_0000, ptr_r};
        `BRFX_OFF_WREG:   rmux = {24'h00_0000, wreg_r};
        `BRFX_OFF_STACK:  rmux = {21'h00_0000, stk_data};
        `BRFX_OFF_WDOG:   rmux = {15'h0000, psa_r, psc_r, wcnt_r};
        `BRFX_OFF_EXEC:   rmux = {24'h00_0000, lastop_r, ncyc_r, st_r};
        default:
            if (a_addr_r >= `BRFX_OFF_FILE)
                rmux = {24'h00_0000, file_flat[a_addr_r[6:2]*8 +: 8]};
    endcase
end

// the wait state lets a write in the prior data phase land before the read
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        hreadyout <= 1'b1;
        hrdata    <= 32'h0000_0000;
        hresp     <= 1'b0;
    end
    else
    begin
        hresp <= 1'b0;
        if (ap & ~hwrite)
            hreadyout <= 1'b0;
        else if (a_rd_r & ~hreadyout)
        begin
            hreadyout <= 1'b1;
            hrdata    <= rmux;
        end
    end
end

endmodule
`default_nettype wire

// ===== testbench/brfx_stack_model.sv
/*
 * brfx_stack_model.sv - return stack and watchdog stand-in for brfx_exec.
 * Assumes one-clock pulses on stk_push, wdog_clr and psc_clr.
 */
`timescale 1ns/1ps
`default_nettype none
module brfx_stack_model
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // pulses from the core
    input wire logic        stk_push,
    input wire logic [10:0] stk_data,
    input wire logic        wdog_clr,
    input wire logic        psc_clr
);
    logic [10:0] stack_q [$];
    integer      push_n = 0;
    integer      wd_n = 0;
    integer      psc_n = 0;
    // no depth limit: overwrite of the real stack is not modelled
    always @(posedge clk)
    begin
        if (rstn && stk_push === 1'b1)
        begin
            stack_q.push_front(stk_data);
            push_n++;
        end
        if (rstn && wdog_clr === 1'b1)
            wd_n++;
        if (rstn && psc_clr === 1'b1)
            psc_n++;
    end
endmodule
`default_nettype wire

// ===== testbench/brfx_exec_props.sv
/*
 * brfx_exec_props.sv - port assertions for brfx_exec.
 * Assumes binding to the design top; one clock, async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module brfx_exec_props
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // far side
    input wire logic        stk_push,
    input wire logic [10:0] stk_data,
    input wire logic        wdog_clr,
    input wire logic        psc_clr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire take = hsel && htrans[1] && hready;
    AST_OKAY: assert property (hresp == 1'b0) else $error("response not okay");
    AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout) else $error("write waited");
    AST_PUSH_GAP: assert property (stk_push |=> !stk_push [*7])
        else $error("push too soon");
    AST_STK_HOLD: assert property (!stk_push |-> $stable(stk_data))
        else $error("return address moved");
    AST_WD_PULSE: assert property (wdog_clr |=> !wdog_clr)
        else $error("clear not a pulse");
    AST_PSC_ONLY_WD: assert property (psc_clr |-> wdog_clr)
        else $error("prescaler clear alone");
    AST_ONE_OP: assert property (!(stk_push && wdog_clr))
        else $error("two ops at once");
endmodule
bind brfx_exec brfx_exec_props chk_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .stk_push(stk_push),
    .stk_data(stk_data), .wdog_clr(wdog_clr), .psc_clr(psc_clr));
`default_nettype wire

// ===== testbench/branch_and_file_op_exec_tb_top.sv
/*
 * branch_and_file_op_exec_tb_top.sv - each op in turn, with random operands, against a model.
 * Assumes brfx_exec, its checker bind and brfx_stack_model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module branch_and_file_op_exec_tb_top;
    logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, seed = 32'h0000_50D7;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    wire         hreadyout, hresp, stk_push, wdog_clr, psc_clr;
    wire  [31:0] hrdata;
    wire  [10:0] stk_data;
    integer      fail_count = 0, tests_run = 0, pushes = 0, wds = 0, pscs = 0, i;
    logic [7:0]  f [32], w = 0, st, r, wcnt, wpsc;
    logic [10:0] ptr = 0, top = 0;
    logic        psa;
    always #2.5 clk = ~clk;
    brfx_exec dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .stk_push(stk_push),
        .stk_data(stk_data), .wdog_clr(wdog_clr), .psc_clr(psc_clr));
    brfx_stack_model p_u (.clk(clk), .rstn(rstn), .stk_push(stk_push),
        .stk_data(stk_data), .wdog_clr(wdog_clr), .psc_clr(psc_clr));
    ////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    // ready sampled at the edge itself, as the bus master sees it
    task wait_rdy;
        integer k;
        k = 0;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            fail_count++;
            conclude;
        end
    endtask
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    ////////////////////////////////////////////////////////////////
    task run_op(input logic [3:0] op);
        logic [4:0] n;
        logic       d;
        logic [8:0] lit;
        logic [1:0] cyc;
        integer     k;
        n = 5'(rnd());
        d = 1'(rnd());
        lit = 9'(rnd());
        f[n] = (rnd() % 4 == 0) ? 8'h01 : 8'(rnd());
        st = 8'(rnd()) & 8'h7C;
        {psa, wpsc, wcnt} = 17'(rnd());
        xfer(1'b1, {1'b1, n, 2'b00}, {24'h00_0000, f[n]});
        xfer(1'b1, 8'h04, {24'h00_0000, st});
        xfer(1'b1, 8'h14, {15'h0000, psa, wpsc, wcnt});
        xfer(1'b1, 8'h00, {7'h00, lit, 3'h0, n, 3'h0, d, op});
        k = 0;
        do begin xfer(1'b0, 8'h18, 32'h0000_0000); k++; end while (rd[1:0] !== 2'b00 && k < 20);
        if (k >= 20)
        begin
            fail_count++;
            conclude;
        end
        if (op == 4'h1)
        begin
            top = ptr + 11'h001;
            pushes++;
        end
        ptr = (op == 4'h1) ? {st[6:5], 1'b0, lit[7:0]} : (op == 4'h2) ? {st[6:5], lit}
            : ptr + 11'h001;
        r = (op == 4'h5) ? ~f[n] : (op == 4'h4) ? 8'h00 : f[n] - 8'h01;
        if (op == 4'h3)
        begin
            st[4:3] = 2'b11;
            wcnt = 8'h00;
            wds++;
            if (psa)
            begin
                wpsc = 8'h00;
                pscs++;
            end
        end
        if (op >= 4'h4)
        begin
            if (op == 4'h4 || d)
                f[n] = r;
            else
                w = r;
            if (op != 4'h7)
                st[2] = (r == 8'h00);
        end
        if (op == 4'h7 && r == 8'h00)
            ptr = ptr + 11'h001;
        cyc = (op == 4'h1 || op == 4'h2 || (op == 4'h7 && r == 8'h00)) ? 2'd2 : 2'd1;
        rchk({1'b1, n, 2'b00}, {24'h00_0000, f[n]});
        rchk(8'h0C, {24'h00_0000, w});
        rchk(8'h04, {24'h00_0000, st});
        rchk(8'h08, {21'h00_0000, ptr});
        rchk(8'h10, {21'h00_0000, top});
        rchk(8'h14, {15'h0000, psa, wpsc, wcnt});
        rchk(8'h18, {24'h00_0000, op, cyc, 2'b00});
        chk(p_u.push_n, pushes);
        if (pushes > 0)
            chk({21'h00_0000, p_u.stack_q[0]}, {21'h00_0000, top});
        chk(p_u.wd_n, wds);
        chk(p_u.psc_n, pscs);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rchk(8'h04, 32'h0000_0018);
        rchk(8'h14, 32'h0001_0000);
        xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
        rchk(8'h40, 32'h0000_0000);
        // op 0 runs as a one-cycle no-op: pointer steps, nothing else moves
        for (i = 0; i < 72; i++)
            run_op(4'(i % 8));
        conclude;
    end
endmodule
`default_nettype wire
